// *** dv/drive_side_model.sv ***
// drive-side model: floppy drive pins and controller shadow writes
// assumes callers enter its tasks just after a rising pclk edge
`timescale 1ns/1ps
module drive_side_model (
   // clock
   input  wire logic            pclk,
   // drive pins, active low
   output logic                 step_pulse_n,
   output logic                 drive_select0_n,
   output logic                 drive_select1_n,
   output logic                 disk_changed_in_n,
   output logic                 write_protect_in_n,
   output logic                 pp_write_protect_in_n,
   // controller register writes
   output fovr_pkg::shadow_wr_s rate_wr,
   output fovr_pkg::shadow_wr_s serial1_fifo_wr,
   output fovr_pkg::shadow_wr_s serial2_fifo_wr
);
   import fovr_pkg::*;

   // ----------------------------------------------------------------
   // idle state: nothing selected, no strobes
   // ----------------------------------------------------------------
   initial begin
      {drive_select0_n, drive_select1_n, step_pulse_n} = 3'h7;
      {disk_changed_in_n, write_protect_in_n, pp_write_protect_in_n} = 3'h7;
      rate_wr         = '0;
      serial1_fifo_wr = '0;
      serial2_fifo_wr = '0;
   end

   // act bits asserted high: {sel0, sel1, step, dskchg, wp, pp_wp}
   task automatic set_pins(input logic [5:0] act);
      {drive_select0_n, drive_select1_n, step_pulse_n, disk_changed_in_n,
       write_protect_in_n, pp_write_protect_in_n} <= ~act;
   endtask

   // one-cycle write strobe; data is scrambled once the strobe drops
   task automatic shadow_write(input int unsigned k, input logic [7:0] d);
      case (k)
         0: rate_wr <= '{1'b1, d};
         1: serial1_fifo_wr <= '{1'b1, d};
         default: serial2_fifo_wr <= '{1'b1, d};
      endcase
      @(posedge pclk);
      rate_wr         <= '{1'b0, ~d};
      serial1_fifo_wr <= '{1'b0, ~d};
      serial2_fifo_wr <= '{1'b0, ~d};
   endtask
endmodule // drive_side_model

// *** dv/tb_floppy_override_shadow_regs.sv ***
// testbench for the override and shadow register bank
// assumes the drive-side model and one wait state apb slave
`timescale 1ns/1ps
module tb_floppy_override_shadow_regs;
   import fovr_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic              pclken;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [3:0]        pstrb;
   logic              step_pulse_n, drive_select0_n, drive_select1_n;
   logic              disk_changed_in_n, write_protect_in_n;
   logic              pp_write_protect_in_n, disk_change_status;
   logic              disk_changed_core_n, write_protect_core_n;
   logic              pp_write_protect_core_n, err;
   shadow_wr_s        rate_wr, serial1_fifo_wr, serial2_fifo_wr;
   int                fails, n_compared;
   // rows: fwp, {sel0,sel1,step,dsk,wp,ppwp}, status, wp_core_n, pp_n
   localparam logic [9:0] rows [9] = '{10'b0_000000_011,
      10'b0_100000_111, 10'b0_010000_111, 10'b0_000100_111,
      10'b0_000010_001, 10'b0_000001_010, 10'b1_000000_011,
      10'b1_100000_100, 10'b1_010000_100};
   localparam logic [11:0] sh_addr [3] = '{ADDR_FLOPPY_RATE_SHADOW,
      ADDR_SERIAL1_FIFO_SHADOW, ADDR_SERIAL2_FIFO_SHADOW};

   floppy_override_shadow_regs DUT (.pclk(pclk), .presetn(presetn),
      .pclken(pclken), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .step_pulse_n(step_pulse_n),
      .drive_select0_n(drive_select0_n), .drive_select1_n(drive_select1_n),
      .disk_changed_in_n(disk_changed_in_n),
      .write_protect_in_n(write_protect_in_n),
      .pp_write_protect_in_n(pp_write_protect_in_n),
      .disk_change_status(disk_change_status),
      .disk_changed_core_n(disk_changed_core_n),
      .write_protect_core_n(write_protect_core_n),
      .pp_write_protect_core_n(pp_write_protect_core_n),
      .rate_wr(rate_wr), .serial1_fifo_wr(serial1_fifo_wr),
      .serial2_fifo_wr(serial2_fifo_wr));
   drive_side_model ptn (.pclk(pclk), .step_pulse_n(step_pulse_n),
      .drive_select0_n(drive_select0_n), .drive_select1_n(drive_select1_n),
      .disk_changed_in_n(disk_changed_in_n),
      .write_protect_in_n(write_protect_in_n),
      .pp_write_protect_in_n(pp_write_protect_in_n), .rate_wr(rate_wr),
      .serial1_fifo_wr(serial1_fifo_wr), .serial2_fifo_wr(serial2_fifo_wr));

   // ----------------------------------------------------------------
   // clock, compares, bus cycles
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk32(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, g);
      chk32(nm, {31'h0, e}, {31'h0, g});
   endtask
   // entered just after a rising edge; pready is sampled at rising edges
   // only, and the watchdog is the one bound on the wait
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0, 4'hF);
      chk32("read data", {24'h0, e}, rd);
      chk1("pslverr", 1'b0, err);
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'hFFFFFF, d}, 4'hF); // upper bits must be ignored
   endtask
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // generous bound: the tests need well under 2000 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      fails = 0; n_compared = 0; presetn = 1'b0; psel = 1'b0; pclken = 1'b1;
      penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0; pstrb = 4'hF;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_reg(ADDR_FORCED_DISK_CHANGE, 8'h03);
      rd_reg(ADDR_FORCED_WRITE_PROTECT, 8'h00);
      for (int k = 0; k < 3; k++) rd_reg(sh_addr[k], RST_SHADOW);
      $display("test reset values done");
      // pin equations with both forced change bits still set
      foreach (rows[i]) begin
         wr_reg(ADDR_FORCED_WRITE_PROTECT, {7'h0, rows[i][9]});
         ptn.set_pins(rows[i][8:3]);
         @(negedge pclk);
         chk1("status", rows[i][2], disk_change_status);
         chk1("dskchg_core_n", ~rows[i][2], disk_changed_core_n);
         chk1("wp_core_n", rows[i][1], write_protect_core_n);
         chk1("pp_wp_core_n", rows[i][0], pp_write_protect_core_n);
         @(posedge pclk);
      end
      ptn.set_pins(6'h00);
      $display("test pin rows done");
      // step clears only the selected drive; zero writes never clear
      ptn.set_pins(6'b101000);
      @(posedge pclk);
      ptn.set_pins(6'b100000);
      @(negedge pclk);
      chk1("status after step", 1'b0, disk_change_status);
      @(posedge pclk);
      ptn.set_pins(6'h00);
      rd_reg(ADDR_FORCED_DISK_CHANGE, 8'h02);
      wr_reg(ADDR_FORCED_DISK_CHANGE, 8'h00);
      rd_reg(ADDR_FORCED_DISK_CHANGE, 8'h02);
      ptn.set_pins(6'b011000);
      @(posedge pclk);
      ptn.set_pins(6'h00);
      rd_reg(ADDR_FORCED_DISK_CHANGE, 8'h00);
      wr_reg(ADDR_FORCED_DISK_CHANGE, 8'hFD);
      rd_reg(ADDR_FORCED_DISK_CHANGE, 8'h01);
      wr_reg(ADDR_FORCED_DISK_CHANGE, 8'hFE);
      rd_reg(ADDR_FORCED_DISK_CHANGE, 8'h03);
      $display("test forced change done");
      // write protect is read/write; lane 0 strobe off loses the write
      wr_reg(ADDR_FORCED_WRITE_PROTECT, 8'h00);
      apb(1'b1, ADDR_FORCED_WRITE_PROTECT, 32'h1, 4'hE);
      rd_reg(ADDR_FORCED_WRITE_PROTECT, 8'h00);
      wr_reg(ADDR_FORCED_WRITE_PROTECT, 8'hFF);
      rd_reg(ADDR_FORCED_WRITE_PROTECT, 8'h01);
      $display("test write protect done");
      // shadows follow every controller write, reserved bits read zero
      for (int k = 0; k < 3; k++) begin
         for (int v = 0; v < 2; v++) begin
            ptn.shadow_write(k, v ? 8'h30 : 8'hFF);
            @(posedge pclk);
            rd_reg(sh_addr[k], (v ? 8'h30 : 8'hFF) &
               (k ? FIFO_READ_MASK : RATE_READ_MASK));
         end
      end
      wr_reg(ADDR_FLOPPY_RATE_SHADOW, 8'hAA);
      rd_reg(ADDR_FLOPPY_RATE_SHADOW, 8'h10);
      $display("test shadows done");
      // clock enable low: a shadow strobe and a drive-0 step are both lost
      pclken <= 1'b0;
      ptn.set_pins(6'b101000);
      ptn.shadow_write(0, 8'h5A);
      ptn.set_pins(6'h00);
      pclken <= 1'b1;
      @(posedge pclk);
      rd_reg(ADDR_FLOPPY_RATE_SHADOW, 8'h10);
      rd_reg(ADDR_FORCED_DISK_CHANGE, 8'h03);
      $display("test clock enable freeze done");
      // unmapped address answers with an error and zero data
      apb(1'b0, 12'h318, 32'h0, 4'hF);
      chk1("unmapped pslverr", 1'b1, err);
      chk32("unmapped data", 32'h0, rd);
      $display("test unmapped done");
      // second reset in mid-run restores the defaults
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_reg(ADDR_FORCED_WRITE_PROTECT, 8'h00);
      rd_reg(ADDR_FLOPPY_RATE_SHADOW, RST_SHADOW);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule // tb_floppy_override_shadow_regs

// *** rtl/floppy_override_shadow_regs.sv ***
// apb register bank: floppy disk-change and write-protect overrides
// plus read-only shadows of write-only floppy and serial settings
// assumes drive pins already synchronous to pclk, all active low
//
// Functional notes
// - host writes one to set a forced change bit; zero never clears
// - drive-1 forced change clears while step and select 1 are active
// - drive-0 forced change clears while step and select 0 are active
// - disk change status ORs selected forced bits with the drive input
// - bit 0 forces drive 0, bit 1 forces drive 1, one is active
// - bits 7 to 2 of forced change register read zero
// - rate shadow: soft reset, power down, reserved, select_a, rate
// - serial-1 shadow: trigger, reserved, dma, clears, fifo enable
// - serial-2 shadow uses the serial-1 layout for port two
// - forced write protect shows protect active while drive selected
// - write protect override acts on drive and parallel-port paths
// - forced write protect resets to zero, drive line passes through
// - core protect = selected and forced, or external, both drives
`timescale 1ns/1ps
module floppy_override_shadow_regs (
   // clock, reset, freeze
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        pclken,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [fovr_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // drive interface pins
   input  wire logic                        step_pulse_n,
   input  wire logic                        drive_select0_n,
   input  wire logic                        drive_select1_n,
   input  wire logic                        disk_changed_in_n,
   input  wire logic                        write_protect_in_n,
   input  wire logic                        pp_write_protect_in_n,
   // toward the floppy core
   output logic                             disk_change_status,
   output logic                             disk_changed_core_n,
   output logic                             write_protect_core_n,
   output logic                             pp_write_protect_core_n,
   // write-only controller register writes seen by the shadows
   input  fovr_pkg::shadow_wr_s             rate_wr,
   input  fovr_pkg::shadow_wr_s             serial1_fifo_wr,
   input  fovr_pkg::shadow_wr_s             serial2_fifo_wr
);

   import fovr_pkg::*;

   // ----------------------------------------------------------------
   // apb phase and address decode
   // ----------------------------------------------------------------
   logic        ready_q;
   logic [31:0] prdata_q;
   logic        access;
   logic        sel_fdc;
   logic        sel_rate;
   logic        sel_ser1;
   logic        sel_ser2;
   logic        sel_fwp;
   logic        addr_hit;
   logic        wr_done;
   logic        wr_fdc;
   logic        wr_fwp;
   logic [7:0]  rd_byte;

   assign access   = psel & penable;
   assign sel_fdc  = (paddr == ADDR_FORCED_DISK_CHANGE);
   assign sel_rate = (paddr == ADDR_FLOPPY_RATE_SHADOW);
   assign sel_ser1 = (paddr == ADDR_SERIAL1_FIFO_SHADOW);
   assign sel_ser2 = (paddr == ADDR_SERIAL2_FIFO_SHADOW);
   assign sel_fwp  = (paddr == ADDR_FORCED_WRITE_PROTECT);
   assign addr_hit = sel_fdc | sel_rate | sel_ser1 | sel_ser2 | sel_fwp;

   // a write lands only at the completing edge, low byte lane enabled
   assign wr_done = access & ready_q & pclken & pwrite & pstrb[0];
   assign wr_fdc  = wr_done & sel_fdc;
   assign wr_fwp  = wr_done & sel_fwp;

   // ----------------------------------------------------------------
   // override flags
   // ----------------------------------------------------------------
   logic force0_q;
   logic force1_q;
   logic fwp_q;
   logic sel0;
   logic sel1;
   logic step_act;
   logic step_clr0;
   logic step_clr1;

   assign sel0      = ~drive_select0_n;
   assign sel1      = ~drive_select1_n;
   assign step_act  = ~step_pulse_n;
   assign step_clr0 = step_act & sel0;
   assign step_clr1 = step_act & sel1;

   // software can only set these; the step of the selected drive clears
   override_bit #(
      .RESET_VAL (RST_FORCED_DISK_CHANGE[FDC_FORCE0_BIT])
   ) u_force0 (
      .pclk    (pclk),
      .presetn (presetn),
      .pclken  (pclken),
      .set     (wr_fdc & pwdata[FDC_FORCE0_BIT]),
      .clr     (step_clr0),
      .q       (force0_q)
   );

   override_bit #(
      .RESET_VAL (RST_FORCED_DISK_CHANGE[FDC_FORCE1_BIT])
   ) u_force1 (
      .pclk    (pclk),
      .presetn (presetn),
      .pclken  (pclken),
      .set     (wr_fdc & pwdata[FDC_FORCE1_BIT]),
      .clr     (step_clr1),
      .q       (force1_q)
   );

   // plain read/write bit, so a zero write does clear it
   override_bit #(
      .RESET_VAL (RST_FORCED_WRITE_PROTECT[FWP_FORCE_BIT])
   ) u_fwp (
      .pclk    (pclk),
      .presetn (presetn),
      .pclken  (pclken),
      .set     (wr_fwp & pwdata[FWP_FORCE_BIT]),
      .clr     (wr_fwp & ~pwdata[FWP_FORCE_BIT]),
      .q       (fwp_q)
   );

   // ----------------------------------------------------------------
   // pin paths toward the floppy core
   // ----------------------------------------------------------------
   logic forced_change;
   logic forced_wp;

   // kept combinational: the core must see the pin without added delay
   assign forced_change        = (sel0 & force0_q) | (sel1 & force1_q);
   assign disk_change_status   = forced_change | ~disk_changed_in_n;
   assign disk_changed_core_n  = ~disk_change_status;
   // one forced bit covers whichever drive is selected
   assign forced_wp            = (sel0 | sel1) & fwp_q;
   assign write_protect_core_n = write_protect_in_n & ~forced_wp;
   assign pp_write_protect_core_n =
      pp_write_protect_in_n & ~forced_wp;

   // ----------------------------------------------------------------
   // shadow registers
   // ----------------------------------------------------------------
   logic [7:0] rate_q;
   logic [7:0] rate_d;
   logic [7:0] ser1_q;
   logic [7:0] ser1_d;
   logic [7:0] ser2_q;
   logic [7:0] ser2_d;

   // reserved positions are dropped at capture so they read zero
   assign rate_d = rate_wr.wr ?
                   (rate_wr.data & RATE_READ_MASK) : rate_q;
   assign ser1_d = serial1_fifo_wr.wr ?
                   (serial1_fifo_wr.data & FIFO_READ_MASK) : ser1_q;
   assign ser2_d = serial2_fifo_wr.wr ?
                   (serial2_fifo_wr.data & FIFO_READ_MASK) : ser2_q;

   // capture on every controller write, frozen with the clock enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_q <= RST_SHADOW;
         ser1_q <= RST_SHADOW;
         ser2_q <= RST_SHADOW;
      end else if (pclken) begin
         rate_q <= rate_d;
         ser1_q <= ser1_d;
         ser2_q <= ser2_d;
      end
   end

   // ----------------------------------------------------------------
   // read mux and apb answer
   // ----------------------------------------------------------------
   logic [7:0] fdc_rd;
   logic [7:0] fwp_rd;

   assign fdc_rd = {6'h00, force1_q, force0_q} & FDC_READ_MASK;
   assign fwp_rd = {7'h00, fwp_q} & FWP_READ_MASK;
   assign rd_byte = sel_fdc  ? fdc_rd :
                    sel_rate ? rate_q :
                    sel_ser1 ? ser1_q :
                    sel_ser2 ? ser2_q :
                    sel_fwp  ? fwp_rd : 8'h00;

   // one wait state so read data comes from a flop, not the mux
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_q  <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (pclken) begin
         ready_q <= access & ~ready_q;
         if (access & ~ready_q) begin
            prdata_q <= {24'h00_0000, rd_byte};
         end
      end
   end

   // a frozen cycle must not complete the transfer: the write lands only
   // on an enabled edge, so the answer is held back while pclken is low
   assign pready  = ready_q & pclken;
   assign prdata  = prdata_q;
   // unmapped words answer with an error; writes to shadows are dropped
   assign pslverr = pready & ~addr_hit;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_write_sets_force: assert property (
      wr_fdc && pwdata[0] |=> force0_q)
      else $error("force0 not set by host write of one");

   a_zero_keeps_force: assert property (
      wr_fdc && !pwdata[1] && force1_q && !step_clr1 |=> force1_q)
      else $error("host write of zero cleared force1");

   a_step_clears_one: assert property (
      pclken && step_clr1 && !(wr_fdc && pwdata[1]) |=> !force1_q)
      else $error("step on drive 1 did not clear force1");

   a_step_clears_zero: assert property (
      pclken && step_clr0 && !(wr_fdc && pwdata[0]) |=> !force0_q)
      else $error("step on drive 0 did not clear force0");

   a_status_follows: assert property (
      sel0 && force0_q |-> disk_change_status && !disk_changed_core_n)
      else $error("selected forced change not reported");

   a_status_quiet: assert property (
      !sel0 && !sel1 |-> disk_change_status == !disk_changed_in_n)
      else $error("status not equal to drive input when idle");

   a_reserved_zero: assert property (
      ready_q && sel_fdc && !pwrite |-> prdata[7:2] == 6'h00)
      else $error("reserved forced change bits read nonzero");

   a_rate_capture: assert property (
      pclken && rate_wr.wr |=> rate_q == ($past(rate_wr.data) & 8'hDF))
      else $error("rate shadow missed a write");

   a_ser1_capture: assert property (
      pclken && serial1_fifo_wr.wr
      |=> ser1_q == ($past(serial1_fifo_wr.data) & 8'hCF))
      else $error("serial 1 shadow missed a write");

   a_ser2_capture: assert property (
      pclken && serial2_fifo_wr.wr
      |=> ser2_q == ($past(serial2_fifo_wr.data) & 8'hCF))
      else $error("serial 2 shadow missed a write");

   a_wp_forced: assert property (
      fwp_q && (sel0 || sel1) |-> !write_protect_core_n)
      else $error("forced write protect not applied");

   a_wp_both_paths: assert property (
      fwp_q && sel1 |-> !write_protect_core_n && !pp_write_protect_core_n)
      else $error("parallel path missed write protect override");

   a_wp_passthru: assert property (
      !fwp_q |-> write_protect_core_n == write_protect_in_n
      && pp_write_protect_core_n == pp_write_protect_in_n)
      else $error("write protect not passed through when inactive");

   a_wp_written: assert property (
      wr_fwp |=> fwp_q == $past(pwdata[0]))
      else $error("forced write protect bit not written");

   a_rate_holds: assert property (
      !rate_wr.wr |=> rate_q == $past(rate_q))
      else $error("rate shadow changed without a write");

   a_one_wait: assert property (
      access && !ready_q && pclken |=> ready_q)
      else $error("apb answer not after one wait state");

   a_ready_pulse: assert property (
      ready_q && pclken |=> !ready_q)
      else $error("apb answer stood longer than one enabled cycle");

   a_ready_frozen: assert property (
      !pclken |-> !pready)
      else $error("apb answer shown while clock enable low");

   c_step_clear: cover property (force0_q && step_clr0 && pclken ##1 !force0_q);
   c_read_force: cover property (ready_q && sel_fdc && !pwrite);
   c_shadow_read: cover property (rate_wr.wr ##[1:20] ready_q && sel_rate);
   c_wp_forced: cover property (fwp_q && sel0 && write_protect_in_n);

endmodule // floppy_override_shadow_regs

// *** rtl/fovr_pkg.sv ***
// package for the floppy override and shadow register bank
// assumes an apb host with 32-bit data and 12-bit byte addresses
package fovr_pkg;

   // ----------------------------------------------------------------
   // register indices and byte addresses
   // ----------------------------------------------------------------
   localparam int unsigned APB_AW = 12;
   // printed indices are not word aligned: byte address is four times
   localparam logic [7:0] IDX_FORCED_DISK_CHANGE = 8'hC1;
   localparam logic [7:0] IDX_FLOPPY_RATE_SHADOW = 8'hC2;
   localparam logic [7:0] IDX_SERIAL1_FIFO_SHADOW = 8'hC3;
   localparam logic [7:0] IDX_SERIAL2_FIFO_SHADOW = 8'hC4;
   localparam logic [7:0] IDX_FORCED_WRITE_PROTECT = 8'hC5;
   localparam logic [11:0] ADDR_FORCED_DISK_CHANGE =
      {2'h0, IDX_FORCED_DISK_CHANGE, 2'h0};
   localparam logic [11:0] ADDR_FLOPPY_RATE_SHADOW =
      {2'h0, IDX_FLOPPY_RATE_SHADOW, 2'h0};
   localparam logic [11:0] ADDR_SERIAL1_FIFO_SHADOW =
      {2'h0, IDX_SERIAL1_FIFO_SHADOW, 2'h0};
   localparam logic [11:0] ADDR_SERIAL2_FIFO_SHADOW =
      {2'h0, IDX_SERIAL2_FIFO_SHADOW, 2'h0};
   localparam logic [11:0] ADDR_FORCED_WRITE_PROTECT =
      {2'h0, IDX_FORCED_WRITE_PROTECT, 2'h0};

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned FDC_FORCE0_BIT = 0;
   localparam int unsigned FDC_FORCE1_BIT = 1;
   localparam int unsigned FWP_FORCE_BIT  = 0;
   localparam int unsigned RATE_SOFT_RESET_BIT = 7;
   localparam int unsigned RATE_POWER_DOWN_BIT = 6;
   localparam int unsigned RATE_SELECT_A_LSB   = 2; // select_a is 4:2
   localparam int unsigned RATE_DRATE_LSB      = 0; // data rate is 1:0
   localparam int unsigned FIFO_RX_TRIGGER_LSB = 6; // rx_trigger_level
   localparam int unsigned FIFO_DMA_MODE_BIT   = 3;
   localparam int unsigned FIFO_TX_CLEAR_BIT   = 2; // tx_queue_clear
   localparam int unsigned FIFO_RX_CLEAR_BIT   = 1; // rx_queue_clear
   localparam int unsigned FIFO_ENABLE_BIT     = 0;

   // readable bit masks; reserved positions read zero
   localparam logic [7:0] FDC_READ_MASK  = 8'h03;
   localparam logic [7:0] FWP_READ_MASK  = 8'h01;
   localparam logic [7:0] RATE_READ_MASK = 8'hDF;
   localparam logic [7:0] FIFO_READ_MASK = 8'hCF;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_FORCED_DISK_CHANGE   = 8'h03;
   localparam logic [7:0] RST_FORCED_WRITE_PROTECT = 8'h00;
   localparam logic [7:0] RST_SHADOW               = 8'h00;

   // write strobe and byte seen on a write-only controller register
   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } shadow_wr_s;

endpackage : fovr_pkg

// *** rtl/override_bit.sv ***
// one override flag with separate set and clear terms
// assumes a single clock; set wins over clear in the same cycle
`timescale 1ns/1ps
module override_bit #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pclken,
   // control
   input  wire logic set,
   input  wire logic clr,
   // state
   output logic      q
);

   logic flag_q;
   logic flag_d;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // an event landing on the clearing cycle must not be lost
   assign flag_d = set ? 1'b1 : (clr ? 1'b0 : flag_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= RESET_VAL;
      end else if (pclken) begin
         flag_q <= flag_d;
      end
   end

   assign q = flag_q;

endmodule // override_bit
